// File: src/dwsc_pkg.sv
// shared constants for the dual wiper serial control link
package dwsc_pkg;
    localparam int          WORD_W        = 16;
    localparam int          POS_W         = 7;
    localparam logic [6:0]  POS_RESET     = 7'h3F;
    localparam logic [6:0]  POS_MUTE      = 7'h40;
    localparam int          CH0_POS_LSB   = 0;
    localparam int          CH0_MUTE_BIT  = 6;
    localparam int          CH1_POS_LSB   = 8;
    localparam int          CH1_MUTE_BIT  = 14;
    localparam int          CLK_MHZ       = 250;
    localparam int          READY_US      = 10;
    localparam int          READY_CYC     = READY_US * CLK_MHZ;
    localparam int          ZC_WAIT_MS    = 50;
    localparam int          ZC_WAIT_CYC   = ZC_WAIT_MS * 1000 * CLK_MHZ;
    localparam int          HOST_DIV      = 8;
    localparam logic [7:0]  NBITS_RESET   = 8'h10;
    localparam logic [15:0] WIPER_RESET   = 16'h3F3F;
    localparam logic [3:0]  REG_DATA      = 4'h0;
    localparam logic [3:0]  REG_CTRL      = 4'h1;
    localparam logic [3:0]  REG_STAT      = 4'h2;
    localparam logic [3:0]  REG_RDATA     = 4'h3;
endpackage : dwsc_pkg

// File: src/dwsc_link_if.sv
// three-wire link joining host and device ends
`timescale 1ns/1ps
interface dwsc_link_if;
    logic window;
    logic sclk;
    logic data_o;
    logic data_oe;
    logic cascade;

    modport device
    (
        input  window,
        input  sclk,
        input  data_o,
        input  data_oe,
        output cascade
    );
    modport host
    (
        output window,
        output sclk,
        output data_o,
        output data_oe,
        input  cascade
    );
endinterface : dwsc_link_if

// File: src/dwsc_device.sv
// device end: shift register, wiper latch and zero-crossing gate
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module dwsc_device
    import dwsc_pkg::*;
#(
    parameter int READY_CYCLES = dwsc_pkg::READY_CYC,
    parameter int ZC_CYCLES    = dwsc_pkg::ZC_WAIT_CYC
)
(
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    dwsc_link_if.device                 link,
    input  wire logic                   zero_cross_enable_n,
    input  wire logic [1:0]             zero_cross,
    output logic      [dwsc_pkg::POS_W-1:0] wiper0,
    output logic      [dwsc_pkg::POS_W-1:0] wiper1,
    output logic                        ready
);
    import dwsc_pkg::*;

    // ********************************
    // state
    // ********************************
    typedef struct packed {
        logic [2:0]        win_s;
        logic [2:0]        clk_s;
        logic [1:0]        dat_s;
        logic [1:0]        zce_s;
        logic [3:0]        zc_s;
        logic [15:0]       shift;
        // pending words wait here while the zero-crossing gate is armed
        logic [15:0]       pend;
        logic [1:0]        pend_v;
        logic [31:0]       zc_cnt;
        logic [31:0]       rdy_cnt;
        logic              ready;
        logic [POS_W-1:0]  w0;
        logic [POS_W-1:0]  w1;
        logic              cout;
    } dwsc_dev_s;

    dwsc_dev_s s_q;
    dwsc_dev_s s_d;

    // line level: driven value or, when floating, the loop-back cascade
    logic din;
    assign din = link.data_oe ? link.data_o : link.cascade;

    // mute overrides the position bits
    function automatic logic [POS_W-1:0] decode(input logic [5:0] pos, input logic mute);
        decode = mute ? POS_MUTE : {1'b0, pos};
    endfunction : decode

    // ********************************
    // next state
    // ********************************
    always_comb
    begin
        logic win;
        logic win_fall;
        logic rise;
        logic zce_on;
        logic [POS_W-1:0] n0;
        logic [POS_W-1:0] n1;
        win      = 1'b0;
        win_fall = 1'b0;
        rise     = 1'b0;
        zce_on   = 1'b0;
        n0       = '0;
        n1       = '0;
        s_d      = s_q;

        // ********************************
        // pin synchronisers
        // ********************************
        // only stage 1 reads the raw pins
        s_d.win_s = {s_q.win_s[1:0], link.window};
        s_d.clk_s = {s_q.clk_s[1:0], link.sclk};
        s_d.dat_s = {s_q.dat_s[0], din};
        s_d.zce_s = {s_q.zce_s[0], zero_cross_enable_n};
        // low pair is stage 1, high pair stage 2, one bit per channel
        s_d.zc_s  = {s_q.zc_s[1:0], zero_cross};
        // window, clock and data see equal depth, so data lines up with its edge
        win      = s_q.win_s[1];
        win_fall = s_q.win_s[2] & ~s_q.win_s[1];
        rise     = s_q.clk_s[1] & ~s_q.clk_s[2];
        zce_on   = ~s_q.zce_s[1];

        // ********************************
        // power-up readiness
        // ********************************
        // edges seen before this point are dropped, not queued
        if (!s_q.ready)
        begin
            s_d.rdy_cnt = s_q.rdy_cnt + 32'h1;
            if (s_q.rdy_cnt >= 32'(READY_CYCLES - 1))
                s_d.ready = 1'b1;
        end

        // ********************************
        // shift register
        // ********************************
        // bits enter at the top, so the oldest bit always sits at bit 0
        // shifting needs the window open; closed window holds contents
        if (s_q.ready && win && rise)
        begin
            s_d.shift = {s_q.dat_s[1], s_q.shift[15:1]};
        end
        s_d.cout = s_d.shift[0];

        // ********************************
        // wiper latch and zero-crossing gate
        // ********************************
        // a full loop-back circulation lands the old word, so no special case
        if (s_q.ready && win_fall)
        begin
            n0 = decode(s_q.shift[CH0_POS_LSB +: 6], s_q.shift[CH0_MUTE_BIT]);
            n1 = decode(s_q.shift[CH1_POS_LSB +: 6], s_q.shift[CH1_MUTE_BIT]);
            if (zce_on)
            begin
                s_d.pend   = {1'b0, n1, 1'b0, n0};
                s_d.pend_v = 2'h3;
                s_d.zc_cnt = '0;
            end
            else
            begin
                s_d.w0     = n0;
                s_d.w1     = n1;
                s_d.pend_v = 2'h0;
            end
        end
        else if (s_q.pend_v != 2'h0)
        begin
            // each channel clears only its own pending bit, so a quiet channel
            // never holds back the other; a new close restarts the count
            s_d.zc_cnt = s_q.zc_cnt + 32'h1;
            // timeout, or enable released: apply what is pending
            if (s_q.zc_cnt >= 32'(ZC_CYCLES - 1) || !zce_on)
            begin
                if (s_q.pend_v[0]) s_d.w0 = s_q.pend[6:0];
                if (s_q.pend_v[1]) s_d.w1 = s_q.pend[14:8];
                s_d.pend_v = 2'h0;
            end
            else
            begin
                if (s_q.pend_v[0] && s_q.zc_s[2])
                begin
                    s_d.w0        = s_q.pend[6:0];
                    s_d.pend_v[0] = 1'b0;
                end
                if (s_q.pend_v[1] && s_q.zc_s[3])
                begin
                    s_d.w1        = s_q.pend[14:8];
                    s_d.pend_v[1] = 1'b0;
                end
            end
        end
    end

    // ********************************
    // registers
    // ********************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q       <= '0;
            // shift register starts as the power-up wipers, so a loop-back
            // read before any write returns position 63 on both channels
            s_q.shift <= WIPER_RESET;
            s_q.pend  <= WIPER_RESET;
            s_q.w0    <= POS_RESET;
            s_q.w1    <= POS_RESET;
            s_q.cout  <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign link.cascade = s_q.cout;
    assign wiper0       = s_q.w0;
    assign wiper1       = s_q.w1;
    assign ready        = s_q.ready;
endmodule : dwsc_device

// File: src/dwsc_host.sv
// host end: register port driving the three-wire link
`timescale 1ns/1ps
module dwsc_host
    import dwsc_pkg::*;
#(
    parameter int DIV = dwsc_pkg::HOST_DIV
)
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    dwsc_link_if.host        link,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata
);
    import dwsc_pkg::*;

    typedef enum logic [1:0]
    {
        H_IDLE  = 2'b00,
        H_OPEN  = 2'b01,
        H_SHIFT = 2'b10,
        H_CLOSE = 2'b11
    } dwsc_hst_e;

    typedef struct packed {
        dwsc_hst_e   st;
        logic [15:0] tx;
        logic [15:0] rx;
        logic [7:0]  bits;
        logic [7:0]  nbits;
        logic        readback;
        logic [7:0]  div;
        logic        window;
        logic        sclk;
        logic        dout;
        logic        doe;
        logic [1:0]  cas_s;
        logic [15:0] rdata;
    } dwsc_hst_s;

    dwsc_hst_s s_q;
    dwsc_hst_s s_d;

    // ********************************
    // next state
    // ********************************
    always_comb
    begin
        logic tick;
        tick    = (s_q.div == 8'(DIV - 1));
        s_d     = s_q;
        s_d.cas_s = {s_q.cas_s[0], link.cascade};
        s_d.div = tick ? 8'h0 : s_q.div + 8'h1;
        s_d.rdata = '0;
        if (rd)
        begin
            unique case (addr)
                REG_DATA:  s_d.rdata = s_q.tx;
                REG_CTRL:  s_d.rdata = {7'h0, s_q.readback, s_q.nbits};
                REG_STAT:  s_d.rdata = {15'h0, s_q.st != H_IDLE};
                REG_RDATA: s_d.rdata = s_q.rx;
                default:   s_d.rdata = '0;
            endcase
        end
        if (wr && addr == REG_DATA && s_q.st == H_IDLE)
            s_d.tx = wdata;
        if (wr && addr == REG_CTRL && s_q.st == H_IDLE)
        begin
            s_d.nbits    = wdata[7:0];
            s_d.readback = wdata[8];
            s_d.st       = H_OPEN;
            s_d.bits     = '0;
            s_d.window   = 1'b1;
            s_d.doe      = ~wdata[8];
            s_d.dout     = s_q.tx[0];
            s_d.div      = '0;
        end
        else if (tick)
        begin
            unique case (s_q.st)
                H_IDLE: ;
                H_OPEN: s_d.st = H_SHIFT;
                H_SHIFT:
                begin
                    if (!s_q.sclk)
                    begin
                        s_d.sclk = 1'b1;
                        s_d.rx   = {s_q.cas_s[1], s_q.rx[15:1]};
                        s_d.bits = s_q.bits + 8'h1;
                    end
                    else
                    begin
                        s_d.sclk = 1'b0;
                        s_d.tx   = {s_q.tx[0], s_q.tx[15:1]};
                        s_d.dout = s_q.tx[1];
                        // closes after nbits clocks (256 when nbits is 0); nothing holds it to whole words
                        if (s_q.bits == s_q.nbits) s_d.st = H_CLOSE;
                    end
                end
                H_CLOSE:
                begin
                    s_d.window = 1'b0;
                    s_d.doe    = 1'b0;
                    s_d.st     = H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q       <= '0;
            s_q.nbits <= NBITS_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign link.window  = s_q.window;
    assign link.sclk    = s_q.sclk;
    assign link.data_o  = s_q.dout;
    assign link.data_oe = s_q.doe;
    assign rdata        = s_q.rdata;
endmodule : dwsc_host

// File: verification/dwsc_link_monitor.sv
// link checker: timing and framing relations on the three-wire link
`timescale 1ns/1ps
module dwsc_link_monitor
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic window,
    input wire logic sclk,
    input wire logic data_o,
    input wire logic data_oe,
    input wire logic cascade
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ****
    // link assertions
    // ****
    chk_sclk_in_window: assert property (sclk |-> window)
        else $error("serial clock high outside the transfer window");
    chk_window_opens_low: assert property ($rose(window) |-> !sclk)
        else $error("window opened with serial clock high");
    chk_data_setup: assert property ($rose(sclk) |-> $stable(data_o) && $stable(data_oe))
        else $error("data moved at the sampling edge");
    chk_sclk_high_span: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
        else $error("serial clock high phase not eight cycles");
    chk_sclk_low_span: assert property ($fell(sclk) |-> (!sclk) [*8])
        else $error("serial clock low phase too short");
    chk_idle_cascade: assert property ((!window) [*8] |-> $stable(cascade))
        else $error("cascade moved while window closed");
    chk_cascade_in_frame: assert property ($changed(cascade) |-> window)
        else $error("cascade changed outside a transfer");
    chk_oe_in_frame: assert property ($rose(data_oe) |-> window)
        else $error("host drove data outside a transfer");

    // ****
    // covers
    // ****
    cov_open: cover property ($rose(window));
    cov_close: cover property ($fell(window));
    cov_loop: cover property ($rose(sclk) && !data_oe);
endmodule : dwsc_link_monitor

// File: verification/dwsc_tb_top.sv
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
module dwsc_tb_top;
    import dwsc_pkg::*;
    localparam int RDY = 20;
    localparam int ZC  = 200;
    logic             clk = 1'b0;
    logic             rst_b = 1'b0;
    logic [3:0]       addr = 4'h0;
    logic [15:0]      wdata = 16'h0000;
    logic             wr = 1'b0;
    logic             rd = 1'b0;
    logic [15:0]      rdata;
    logic             zce_n = 1'b1;
    logic [1:0]       zc = 2'h0;
    logic [POS_W-1:0] wiper0;
    logic [POS_W-1:0] wiper1;
    logic             ready;
    logic [15:0]      wire_word = 16'h0000;
    logic             sclk_q = 1'b0;
    logic [15:0]      rv;
    int               n_mismatch = 0;
    int               compares = 0;
    int               i;

    dwsc_link_if link();
    dwsc_device #(.READY_CYCLES(RDY), .ZC_CYCLES(ZC)) i_dwsc_device
    (.clk(clk), .rst_b(rst_b), .link(link), .zero_cross_enable_n(zce_n),
     .zero_cross(zc), .wiper0(wiper0), .wiper1(wiper1), .ready(ready));
    dwsc_host i_dwsc_host
    (.clk(clk), .rst_b(rst_b), .link(link), .addr(addr), .wdata(wdata),
     .wr(wr), .rd(rd), .rdata(rdata));
    dwsc_link_monitor i_dwsc_link_monitor
    (.clk(clk), .rst_b(rst_b), .window(link.window), .sclk(link.sclk),
     .data_o(link.data_o), .data_oe(link.data_oe), .cascade(link.cascade));

    always #2 clk = ~clk;

    // ****
    // helpers
    // ****
    // the wire word is rebuilt lsb first from data seen at each serial clock rise
    always @(posedge clk)
    begin
        sclk_q <= link.sclk;
        if (link.window && link.sclk && !sclk_q)
            wire_word <= {link.data_o, wire_word[15:1]};
    end

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk16

    task automatic chk7(input logic [POS_W-1:0] got, input logic [POS_W-1:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t wiper=%h exp=%h", $time, got, exp);
        end
    endtask : chk7

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd

    // a data write while busy must be refused, so it is issued on purpose
    task automatic send(input logic [15:0] w, input logic [7:0] n, input logic lp);
        reg_wr(REG_DATA, w);
        reg_wr(REG_CTRL, {7'h00, lp, n});
        reg_wr(REG_DATA, ~w);
        reg_wr(4'hE, ~w);
        rv = 16'h0001;
        for (i = 0; i < 2000 && rv[0] === 1'b1; i++)
            reg_rd(REG_STAT, rv);
        chk16({15'h0000, rv[0]}, 16'h0000);
        repeat (10) @(posedge clk);
        #1;
    endtask : send

    task automatic complete_run();
        if (n_mismatch == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    // ****
    // scenarios
    // ****
    task automatic t_reset();
        #1;
        chk7(wiper0, POS_RESET);
        chk7(wiper1, POS_RESET);
        for (i = 0; i < RDY + 10 && ready !== 1'b1; i++)
            @(posedge clk);
        #1;
        chk16({15'h0000, ready}, 16'h0001);
    endtask : t_reset

    task automatic t_write();
        send(16'h8A15, 8'h10, 1'b0);
        chk16(wire_word, 16'h8A15);
        chk7(wiper0, 7'h15);
        chk7(wiper1, 7'h0A);
        send(16'h6A3F, 8'h20, 1'b0);
        chk7(wiper0, 7'h3F);
        chk7(wiper1, POS_MUTE);
        reg_rd(REG_RDATA, rv);
        chk16(rv, 16'h6A3F);
        chk16(wire_word, 16'h6A3F);
    endtask : t_write

    task automatic t_cascade();
        send(16'h1234, 8'h10, 1'b0);
        reg_rd(REG_RDATA, rv);
        chk16(rv, 16'h6A3F);
        chk7(wiper0, 7'h34);
        send(16'h0000, 8'h10, 1'b1);
        reg_rd(REG_RDATA, rv);
        chk16(rv, 16'h1234);
        chk7(wiper0, 7'h34);
        chk7(wiper1, 7'h12);
    endtask : t_cascade

    task automatic t_zero_cross();
        @(posedge clk);
        zce_n <= 1'b0;
        send(16'h0341, 8'h10, 1'b0);
        chk7(wiper0, 7'h34);
        @(posedge clk);
        zc <= 2'h1;
        repeat (10) @(posedge clk);
        #1;
        chk7(wiper0, POS_MUTE);
        chk7(wiper1, 7'h12);
        for (i = 0; i < ZC + 200 && wiper1 !== 7'h03; i++)
        begin
            @(posedge clk);
            #1;
        end
        chk7(wiper1, 7'h03);
        @(posedge clk);
        zc <= 2'h0;
        send(16'h0506, 8'h10, 1'b0);
        chk7(wiper0, POS_MUTE);
        @(posedge clk);
        zce_n <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk7(wiper0, 7'h06);
        chk7(wiper1, 7'h05);
    endtask : t_zero_cross

    initial
    begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_write();
        t_cascade();
        t_zero_cross();
        complete_run();
    end

    initial
    begin
        #100000;
        n_mismatch++;
        complete_run();
    end
endmodule : dwsc_tb_top
